/* core/smpr_responder.sv */
// Purpose: decodes management report requests and streams the answers
// Assumes: request words and attachment state come from the link layer
// Notes: the per-phy report answer itself is built elsewhere
// Behaviour
// [R1] Function 01h selects the general report; request bytes one to three ignored.
// [R2] Result byte is 00h when accepted, 01h for unsupported functions.
// [R3] Every response starts with unit type byte 41h.
// [R4] General report byte two holds the number of phys.
// [R5] General report byte three holds the phy the request came in on.
// [R6] General report carries the device name.
// [R7] In phy bitmasks the LSB is phy 0, MSB is phy 63.
// [R8] Active bitmask marks attached phys that finished link reset.
// [R9] One bitmask marks phys attached to fanout expanders.
// [R10] Another bitmask marks phys attached to edge expanders.
// [R11] Initiator bitmask marks phys attached to SAS initiators.
// [R12] Target bitmask marks phys attached to SAS targets.
// [R13] SATA bitmask marks phys attached to SATA targets.
// [R14] Phy rate field packs one four-bit code per phy.
// [R15] Rate codes 0h to 4h only; 5h to Fh are never sent.
// [R16] Supported functions bitmask: MSB is code 00h, LSB is code FFh.
// [R17] Function 02h is the SATA capabilities request, answered only when capable.
// [R18] Without SATA attachment support, function 02h is reported unsupported.
// [R19] SATA capable bit shows SATA target attachment support.
// [R20] Queuing bit shows only the responder's own queued command support.
// [R21] SATA report byte two is the SATA version, 00h for 1.0.
// [R22] Byte three is the initiator share limit; beyond it connections get rejected.
// [R23] Function 10h passes the byte three phy index to the phy reporter.
// [R24] Reserved response bytes are zero; reserved request bytes are ignored.
`timescale 1ns/100ps
`default_nettype none
module smpr_responder
   import smpr_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // request words
   input wire logic req_valid,
   output logic req_ready,
   input wire smpr_req_type req,
   input wire logic [5:0] req_rx_phy,
   // response byte stream
   output logic resp_valid,
   input wire logic resp_ready,
   output logic [7:0] resp_data,
   output logic resp_last,
   // attachment state per phy
   input wire smpr_att_type att,
   // hand-off to the per-phy reporter
   output logic phy_rpt_valid,
   output logic [5:0] phy_rpt_sel,
   // stp connection sharing
   input wire logic [7:0] stp_share_count,
   output logic stp_reject
);

   // ***************************************
   // register file
   // ***************************************
   logic [31:0] ctrl;
   logic [31:0] cfg;
   logic [63:0] dev_name;
   logic [63:0] rate_raw;
   logic wr_pend;
   logic [7:0] dp_addr;
   logic [7:0] req_count;
   logic [7:0] last_fn;
   logic [5:0] last_phy;
   smpr_state_type state;
   smpr_state_type next_state;
   logic addr_ok;

   assign addr_ok = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         dp_addr <= 8'h00;
      end else if (hready) begin
         wr_pend <= addr_ok && hwrite;
         dp_addr <= haddr[7:0];
      end
   end

   // sub-word writes are taken as whole words
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= CTRL_RESET;
         cfg <= CFG_RESET;
         dev_name <= NAME_RESET;
         rate_raw <= RATE_RESET;
      end else if (wr_pend) begin
         unique case (dp_addr)
            ADDR_CTRL: ctrl <= hwdata;
            ADDR_CFG: cfg <= hwdata;
            ADDR_NAME_LO: dev_name[31:0] <= hwdata;
            ADDR_NAME_HI: dev_name[63:32] <= hwdata;
            ADDR_RATE_LO: rate_raw[31:0] <= hwdata;
            ADDR_RATE_HI: rate_raw[63:32] <= hwdata;
            default: ;
         endcase
      end
   end

   // read mux on the data-phase address; unmapped reads as zero
   always_comb begin
      hrdata = 32'h0000_0000;
      unique case (dp_addr)
         ADDR_CTRL: hrdata = {29'h0, ctrl[2:0]};
         ADDR_CFG: hrdata = cfg;
         ADDR_NAME_LO: hrdata = dev_name[31:0];
         ADDR_NAME_HI: hrdata = dev_name[63:32];
         ADDR_RATE_LO: hrdata = rate_raw[31:0];
         ADDR_RATE_HI: hrdata = rate_raw[63:32];
         ADDR_STATUS: begin
            hrdata[STAT_BUSY_BIT] = (state == ST_SEND);
            hrdata[STAT_FN_LSB +: 8] = last_fn;
            hrdata[STAT_PHY_LSB +: 6] = last_phy;
            hrdata[STAT_CNT_LSB +: 8] = req_count;
         end
         default: ;
      endcase
   end

   // ***************************************
   // response content
   // ***************************************
   logic sata_cap;
   logic [63:0] rate_clean;
   logic [255:0] fsup;
   smpr_frame_type next_frame;
   smpr_frame_type frame;
   logic [6:0] next_len;
   logic [6:0] len;
   logic [6:0] cnt;
   logic accept;
   logic rate_ok;

   assign sata_cap = ctrl[CTRL_SATA_BIT];

   // reserved codes are reported as present, rate unknown
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_rate
         assign rate_clean[4*gi +: 4] = (rate_raw[4*gi +: 4] > RATE_MAX) ? RATE_UNKNOWN : rate_raw[4*gi +: 4]; // R15
      end
   endgenerate

   always_comb begin
      fsup = '0;
      fsup[255 - int'(FN_GENERAL)] = 1'b1; // R16
      fsup[255 - int'(FN_PHY)] = 1'b1;
      fsup[255 - int'(FN_SATA)] = sata_cap; // R18
   end

   // most significant byte first, so bit 0 (phy 0) lands last
   function automatic smpr_frame_type put64(input smpr_frame_type f, input int ofs, input logic [63:0] v);
      smpr_frame_type r;
      r = f;
      for (int k = 0; k < 8; k++) begin
         r[ofs + k] = v[63 - 8*k -: 8];
      end
      return r;
   endfunction

   always_comb begin
      next_frame = '0; // R24
      next_len = SHORT_LEN;
      next_frame[OFS_RESULT] = RES_UNKNOWN; // R2
      if (req.fn == FN_GENERAL) begin // R1
         next_len = GEN_LEN;
         next_frame[OFS_RESULT] = RES_ACCEPTED;
         next_frame[OFS_REV] = cfg[CFG_REV_LSB +: 8];
         next_frame[OFS_NPHY] = cfg[CFG_NPHY_LSB +: 8]; // R4
         next_frame[OFS_RXPHY] = {2'b00, req_rx_phy}; // R5
         next_frame = put64(next_frame, OFS_NAME, dev_name); // R6
         next_frame = put64(next_frame, OFS_ACTIVE, att.active); // R7 R8
         next_frame = put64(next_frame, OFS_FANOUT, att.fanout); // R9
         next_frame = put64(next_frame, OFS_EDGE, att.edge_exp); // R10
         next_frame = put64(next_frame, OFS_INIT, att.initiator); // R11
         next_frame = put64(next_frame, OFS_TARGET, att.target); // R12
         next_frame = put64(next_frame, OFS_SATA, att.sata); // R13
         next_frame = put64(next_frame, OFS_RATE, rate_clean); // R14
         for (int k = 0; k < 32; k++) begin
            next_frame[OFS_FUNC + k] = fsup[255 - 8*k -: 8]; // R16
         end
      end else if (req.fn == FN_SATA && sata_cap) begin // R17 R18
         next_frame[OFS_RESULT] = RES_ACCEPTED;
         next_frame[OFS_CAPS] = {6'h00, ctrl[CTRL_QUEUE_BIT], sata_cap}; // R19 R20
         next_frame[OFS_VER] = cfg[CFG_VER_LSB +: 8]; // R21
         next_frame[OFS_MAXINIT] = cfg[CFG_INIT_LSB +: 8]; // R22
      end
   end

   // connection manager rejects once the share limit is reached
   assign stp_reject = (stp_share_count >= cfg[CFG_INIT_LSB +: 8]); // R22

   // ***************************************
   // request handling and streaming
   // ***************************************
   assign req_ready = (state == ST_IDLE) && ctrl[CTRL_EN_BIT];
   assign accept = req_valid && req_ready;
   assign resp_valid = (state == ST_SEND);

   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: if (accept && req.fn != FN_PHY) next_state = ST_SEND;
         ST_SEND: if (resp_ready && resp_last) next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // snapshot on accept so a changing link state cannot tear a frame
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame <= '0;
         len <= SHORT_LEN;
         cnt <= 7'h00;
         resp_data <= 8'h00;
         resp_last <= 1'b0;
      end else if (state == ST_IDLE && next_state == ST_SEND) begin
         frame <= next_frame;
         len <= next_len;
         cnt <= 7'h00;
         resp_data <= IU_RESPONSE; // R3
         resp_last <= 1'b0;
      end else if (state == ST_SEND && resp_ready && !resp_last) begin
         cnt <= cnt + 7'h01;
         resp_data <= frame[cnt];
         resp_last <= (cnt + 7'h01 == len);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phy_rpt_valid <= 1'b0;
         phy_rpt_sel <= 6'h00;
      end else begin
         phy_rpt_valid <= accept && req.fn == FN_PHY; // R23
         if (accept && req.fn == FN_PHY) begin
            phy_rpt_sel <= req.phy_id[5:0]; // R23
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_count <= 8'h00;
         last_fn <= 8'h00;
         last_phy <= 6'h00;
      end else if (accept) begin
         req_count <= req_count + 8'h01;
         last_fn <= req.fn;
         last_phy <= req_rx_phy;
      end
   end

   // ***************************************
   // assertions
   // ***************************************
   // every nibble of the rate field, not just the top byte
   always_comb begin
      rate_ok = 1'b1;
      for (int k = 0; k < 8; k++) begin
         if (frame[OFS_RATE + k][7:4] > RATE_MAX || frame[OFS_RATE + k][3:0] > RATE_MAX) begin
            rate_ok = 1'b0;
         end
      end
   end

   // reassembles a 64-bit field, most significant byte first
   function automatic logic [63:0] get64(input smpr_frame_type f, input int ofs);
      logic [63:0] v;
      v = '0;
      for (int k = 0; k < 8; k++) begin
         v[63 - 8*k -: 8] = f[ofs + k];
      end
      return v;
   endfunction

   sequence s_gen;
      accept && req.fn == FN_GENERAL;
   endsequence

   sequence s_start;
      state == ST_IDLE && next_state == ST_SEND;
   endsequence

   iu_byte_a: assert property (@(posedge hclk) disable iff (!hresetn) // R3
      s_start |=> resp_valid && resp_data == IU_RESPONSE)
      else $error("first byte is not the unit type");

   result_out_a: assert property (@(posedge hclk) disable iff (!hresetn) // R2
      (resp_valid && cnt == 7'h00 && resp_ready) |=> resp_data == frame[OFS_RESULT])
      else $error("result byte not second");

   nphy_a: assert property (@(posedge hclk) disable iff (!hresetn) // R4
      s_gen |=> frame[OFS_NPHY] == cfg[CFG_NPHY_LSB +: 8] && len == GEN_LEN)
      else $error("phy count wrong");

   rx_phy_a: assert property (@(posedge hclk) disable iff (!hresetn) // R5
      s_gen |=> frame[OFS_RXPHY] == {2'b00, $past(req_rx_phy)})
      else $error("receiving phy wrong");

   active_map_a: assert property (@(posedge hclk) disable iff (!hresetn) // R8
      s_gen |=> frame[OFS_ACTIVE + 7] == $past(att.active[7:0]))
      else $error("phy 0 not in low byte");

   func_map_a: assert property (@(posedge hclk) disable iff (!hresetn) // R16
      s_gen |=> frame[OFS_FUNC][6] && frame[OFS_FUNC + 2][7] && !frame[OFS_FUNC][7])
      else $error("supported functions misplaced");

   sata_unsup_a: assert property (@(posedge hclk) disable iff (!hresetn) // R18
      (accept && req.fn == FN_SATA && !sata_cap) |=> frame[OFS_RESULT] == RES_UNKNOWN)
      else $error("sata function answered while unsupported");

   rate_code_a: assert property (@(posedge hclk) disable iff (!hresetn) // R15
      s_gen |=> rate_ok)
      else $error("reserved rate code sent");

   phy_sel_a: assert property (@(posedge hclk) disable iff (!hresetn) // R23
      (accept && req.fn == FN_PHY) |=> phy_rpt_valid && phy_rpt_sel == $past(req.phy_id[5:0])
         ##1 !phy_rpt_valid || $past(accept))
      else $error("phy hand-off wrong");

   frame_end_a: assert property (@(posedge hclk) disable iff (!hresetn) // R24
      (resp_valid && resp_ready && resp_last) |=> state == ST_IDLE && cnt == len)
      else $error("frame length wrong");

   name_field_a: assert property (@(posedge hclk) disable iff (!hresetn) // R6
      s_gen |=> get64(frame, OFS_NAME) == $past(dev_name))
      else $error("device name wrong");

   att_maps_a: assert property (@(posedge hclk) disable iff (!hresetn) // R9 R10 R11 R12 R13
      s_gen |=> get64(frame, OFS_FANOUT) == $past(att.fanout) && get64(frame, OFS_EDGE) == $past(att.edge_exp)
         && get64(frame, OFS_INIT) == $past(att.initiator) && get64(frame, OFS_TARGET) == $past(att.target)
         && get64(frame, OFS_SATA) == $past(att.sata))
      else $error("attachment bitmask wrong");

   caps_byte_a: assert property (@(posedge hclk) disable iff (!hresetn) // R19 R20 R21
      (accept && req.fn == FN_SATA && sata_cap) |=> frame[OFS_CAPS] == {6'h00, $past(ctrl[CTRL_QUEUE_BIT]), 1'b1}
         && frame[OFS_VER] == $past(cfg[CFG_VER_LSB +: 8]))
      else $error("sata capability bytes wrong");

   init_limit_a: assert property (@(posedge hclk) disable iff (!hresetn) // R22
      (accept && req.fn == FN_SATA && sata_cap) |=> frame[OFS_MAXINIT] == $past(cfg[CFG_INIT_LSB +: 8]))
      else $error("initiator limit byte wrong");

   unknown_fn_a: assert property (@(posedge hclk) disable iff (!hresetn) // R2
      (accept && req.fn != FN_GENERAL && req.fn != FN_SATA && req.fn != FN_PHY)
         |=> frame[OFS_RESULT] == RES_UNKNOWN && len == SHORT_LEN)
      else $error("unknown function not refused");

   reserved_zero_a: assert property (@(posedge hclk) disable iff (!hresetn) // R24
      s_gen |=> frame[OFS_RXPHY + 1] == 8'h00 && frame[OFS_NAME - 1] == 8'h00
         && frame[OFS_SATA + 8] == 8'h00 && frame[OFS_RATE - 1] == 8'h00)
      else $error("reserved byte not zero");

endmodule
`default_nettype wire

/* core/smpr_pkg.sv */
// Purpose: constants and types for the management report responder
// Assumes: one 32-bit AHB-Lite register window, byte-wide response stream
// Notes: frame byte offsets exclude the leading unit type byte
package smpr_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CFG = 8'h04;
   localparam logic [7:0] ADDR_NAME_LO = 8'h08;
   localparam logic [7:0] ADDR_NAME_HI = 8'h0c;
   localparam logic [7:0] ADDR_RATE_LO = 8'h10;
   localparam logic [7:0] ADDR_RATE_HI = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   // control bits and config fields
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_SATA_BIT = 1;
   localparam int CTRL_QUEUE_BIT = 2;
   localparam int CFG_NPHY_LSB = 0;
   localparam int CFG_VER_LSB = 8;
   localparam int CFG_INIT_LSB = 16;
   localparam int CFG_REV_LSB = 24;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_FN_LSB = 8;
   localparam int STAT_PHY_LSB = 16;
   localparam int STAT_CNT_LSB = 24;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam logic [31:0] CFG_RESET = 32'h0001_0010;
   localparam logic [63:0] NAME_RESET = 64'h0000_0000_0000_0000;
   localparam logic [63:0] RATE_RESET = 64'h0000_0000_0000_0000;
   // codes
   localparam logic [7:0] FN_GENERAL = 8'h01;
   localparam logic [7:0] FN_SATA = 8'h02;
   localparam logic [7:0] FN_PHY = 8'h10;
   localparam logic [7:0] RES_ACCEPTED = 8'h00;
   localparam logic [7:0] RES_UNKNOWN = 8'h01;
   localparam logic [7:0] IU_RESPONSE = 8'h41;
   localparam logic [3:0] RATE_UNKNOWN = 4'h1;
   localparam logic [3:0] RATE_MAX = 4'h4;
   // frame layout
   localparam int FRAME_BYTES = 116;
   localparam logic [6:0] GEN_LEN = 7'h74;
   localparam logic [6:0] SHORT_LEN = 7'h04;
   localparam int OFS_RESULT = 0;
   localparam int OFS_REV = 1;
   localparam int OFS_NPHY = 2;
   localparam int OFS_RXPHY = 3;
   localparam int OFS_NAME = 8;
   localparam int OFS_ACTIVE = 16;
   localparam int OFS_FANOUT = 24;
   localparam int OFS_EDGE = 32;
   localparam int OFS_INIT = 40;
   localparam int OFS_TARGET = 48;
   localparam int OFS_SATA = 56;
   localparam int OFS_RATE = 76;
   localparam int OFS_FUNC = 84;
   localparam int OFS_CAPS = 1;
   localparam int OFS_VER = 2;
   localparam int OFS_MAXINIT = 3;

   typedef struct packed {
      logic [7:0] fn;
      logic [15:0] rsv;
      logic [7:0] phy_id;
   } smpr_req_type;

   typedef struct packed {
      logic [63:0] active;
      logic [63:0] fanout;
      logic [63:0] edge_exp;
      logic [63:0] initiator;
      logic [63:0] target;
      logic [63:0] sata;
   } smpr_att_type;

   typedef logic [0:FRAME_BYTES-1][7:0] smpr_frame_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SEND = 2'b10
   } smpr_state_type;
endpackage

/* sim/smpr_initiator.sv */
// Purpose: initiator port model feeding management report requests
// Assumes: one request outstanding at a time
// Notes: stall makes resp_ready toggle every cycle
`timescale 1ns/100ps
`default_nettype none
module smpr_initiator
   import smpr_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // requests
   output logic req_valid,
   input wire logic req_ready,
   output smpr_req_type req,
   output logic [5:0] req_rx_phy,
   // response stream
   input wire logic resp_valid,
   output logic resp_ready,
   input wire logic [7:0] resp_data,
   input wire logic resp_last,
   input wire logic stall
);
   logic [7:0] rx [0:127];
   int cnt;
   logic done;
   // ********************
   // stream sink
   // ********************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         resp_ready <= 1'b0;
         cnt <= 0;
         done <= 1'b0;
      end else begin
         resp_ready <= stall ? ~resp_ready : 1'b1;
         if (req_valid && req_ready) begin
            cnt <= 0;
            done <= 1'b0;
         end else if (resp_valid && resp_ready) begin
            cnt <= cnt + 1;
            done <= resp_last;
         end
      end
   end
   always_ff @(posedge hclk) begin
      if (resp_valid && resp_ready) begin
         rx[cnt[6:0]] <= resp_data;
      end
   end
   // ********************
   // request driver
   // ********************
   initial begin
      req_valid = 1'b0;
      req = '0;
      req_rx_phy = 6'h0;
   end
   task automatic send(input logic [7:0] fn, input logic [15:0] rsv, input logic [7:0] id,
                       input logic [5:0] rxp);
      int n;
      n = 0;
      @(posedge hclk);
      req_valid <= 1'b1;
      req <= '{fn, rsv, id};
      req_rx_phy <= rxp;
      do begin
         @(posedge hclk);
         n++;
      end while (!req_ready && n < 1000);
      // released lines show a changed pattern, not the old request
      req_valid <= 1'b0;
      req <= ~req;
      req_rx_phy <= ~rxp;
   endtask
endmodule
`default_nettype wire

/* sim/smp_report_responder_tb_top.sv */
// Purpose: self-checking bench for the report responder
// Assumes: zero-wait bus slave, model initiator on the request side
// Notes: expected frames are built here byte by byte
`timescale 1ns/100ps
`default_nettype none
module smp_report_responder_tb_top
   import smpr_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, stall;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic req_valid, req_ready, resp_valid, resp_ready, resp_last, phy_rpt_valid, stp_reject;
   logic [7:0] resp_data, share;
   logic [5:0] req_rx_phy, phy_rpt_sel;
   smpr_req_type req;
   smpr_att_type att;
   logic [7:0] exp [0:116];
   logic [7:0] fns [0:4] = '{8'h00, 8'h02, 8'h05, 8'h11, 8'hff};
   int err_total = 0;
   int checks_done = 0;
   assign hready = hreadyout;
   smpr_responder DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .req_valid(req_valid), .req_ready(req_ready), .req(req),
      .req_rx_phy(req_rx_phy), .resp_valid(resp_valid), .resp_ready(resp_ready),
      .resp_data(resp_data), .resp_last(resp_last), .att(att), .phy_rpt_valid(phy_rpt_valid),
      .phy_rpt_sel(phy_rpt_sel), .stp_share_count(share), .stp_reject(stp_reject));
   smpr_initiator u_ini (.hclk(hclk), .hresetn(hresetn), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .req_rx_phy(req_rx_phy), .resp_valid(resp_valid),
      .resp_ready(resp_ready), .resp_data(resp_data), .resp_last(resp_last), .stall(stall));
   // ********************
   // tasks
   // ********************
   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] want);
      checks_done++;
      if (seen !== want) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do begin
         @(posedge hclk);
         n++;
      end while (!hready && n < 200);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      do begin
         @(posedge hclk);
         n++;
      end while (!hready && n < 200);
      rd = hrdata;
      chk("hresp", hresp, 1'b0);
      if (n >= 200) begin
         err_total++;
         stop_test();
      end
   endtask
   task automatic put(input int ofs, input logic [63:0] v);
      for (int k = 0; k < 8; k++) begin
         exp[1 + ofs + k] = v[63 - 8 * k -: 8];
      end
   endtask
   task automatic frame(input logic [7:0] fn, input int n);
      int i;
      i = 0;
      u_ini.send(fn, 16'ha5c3, 8'h00, 6'd5);
      do begin
         @(posedge hclk);
         i++;
      end while (!u_ini.done && i < 1000);
      if (!u_ini.done) begin
         err_total++;
         stop_test();
      end
      chk("stream length", u_ini.cnt, n);
      for (i = 0; i < n; i++) begin
         chk("frame byte", u_ini.rx[i], exp[i]);
      end
   endtask
   // ********************
   // run
   // ********************
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   initial begin
      repeat (50000) @(posedge hclk);
      err_total++;
      stop_test();
   end
   initial begin
      {hresetn, hsel, hwrite, stall} = 4'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'b00;
      hsize = 3'b010;
      share = 8'h0;
      att = '{64'h8000_0000_0000_0001, 64'h2, 64'h0400_0000_0000_0000, 64'h0030_0000,
             64'h1_0000_0000, 64'h8000_0000_0000};
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl reset", rd, CTRL_RESET);
      ahb(1'b0, ADDR_CFG, 32'h0);
      chk("cfg reset", rd, CFG_RESET);
      ahb(1'b1, 8'h1c, 32'hffff_ffff);
      ahb(1'b0, 8'h1c, 32'h0);
      chk("unmapped read", rd, 32'h0);
      exp = '{default: 8'h00};
      exp[0] = IU_RESPONSE;
      exp[1] = RES_UNKNOWN;
      // sata capability still off, so 02h is unknown too
      foreach (fns[j]) begin
         frame(fns[j], 5);
      end
      ahb(1'b1, ADDR_CTRL, 32'h0);
      @(posedge hclk);
      chk("refused when off", req_ready, 1'b0);
      ahb(1'b1, ADDR_CTRL, 32'h3);
      ahb(1'b1, ADDR_CFG, 32'h0302_000c);
      exp[1] = RES_ACCEPTED;
      exp[2] = 8'h01;
      exp[4] = 8'h02;
      frame(FN_SATA, 5);
      ahb(1'b1, ADDR_CTRL, 32'h7);
      exp[2] = 8'h03;
      frame(FN_SATA, 5);
      for (int s = 1; s < 4; s++) begin
         share <= s[7:0];
         repeat (2) @(posedge hclk);
         chk("share limit", stp_reject, s >= 2);
      end
      ahb(1'b1, ADDR_NAME_LO, 32'h89ab_cdef);
      ahb(1'b1, ADDR_NAME_HI, 32'h0123_4567);
      ahb(1'b1, ADDR_RATE_LO, 32'h7432_10f4);
      ahb(1'b1, ADDR_RATE_HI, 32'h0000_5003);
      exp = '{default: 8'h00};
      exp[0] = IU_RESPONSE;
      exp[2] = 8'h03;
      exp[3] = 8'h0c;
      exp[4] = 8'h05;
      put(OFS_NAME, 64'h0123_4567_89ab_cdef);
      put(OFS_ACTIVE, att.active);
      put(OFS_FANOUT, att.fanout);
      put(OFS_EDGE, att.edge_exp);
      put(OFS_INIT, att.initiator);
      put(OFS_TARGET, att.target);
      put(OFS_SATA, att.sata);
      // out-of-range software codes must come out as rate unknown
      put(OFS_RATE, 64'h0000_1003_1432_1014);
      exp[85] = 8'h60;
      exp[87] = 8'h80;
      stall <= 1'b1;
      frame(FN_GENERAL, 117);
      stall <= 1'b0;
      for (int p = 0; p < 2; p++) begin
         u_ini.send(FN_PHY, 16'hffff, p ? 8'h3f : 8'h00, 6'd2);
         #1;
         chk("phy pulse", phy_rpt_valid, 1'b1);
         chk("phy select", phy_rpt_sel, p ? 6'h3f : 6'h00);
         @(posedge hclk);
         #1;
         chk("phy pulse end", phy_rpt_valid, 1'b0);
      end
      // ten requests taken, the last a phy report on phy 2
      ahb(1'b0, ADDR_STATUS, 32'h0);
      chk("status", rd, 32'h0a02_1000);
      ahb(1'b0, ADDR_RATE_HI, 32'h0);
      chk("rate hi readback", rd, 32'h0000_5003);
      stop_test();
   end
endmodule
`default_nettype wire
